/* File: rtl/gpb_map.svh */
// register offsets, field masks and reset values of the port block
`ifndef GPB_MAP_SVH
`define GPB_MAP_SVH
// ************************************************************
// register addresses
// ************************************************************
`define GPB_ADDR_PORT2_DATA 16'hFF02
`define GPB_ADDR_PORT3_DATA 16'hFF03
`define GPB_ADDR_PORT4_DATA 16'hFF04
`define GPB_ADDR_PORT12_DATA 16'hFF0C
`define GPB_ADDR_PORT13_DATA 16'hFF0D
`define GPB_ADDR_PORT2_DIR 16'hFF22
`define GPB_ADDR_PORT3_DIR 16'hFF23
`define GPB_ADDR_PORT4_DIR 16'hFF24
`define GPB_ADDR_PORT12_DIR 16'hFF2C
`define GPB_ADDR_PORT2_PU 16'hFF32
`define GPB_ADDR_PORT3_PU 16'hFF33
`define GPB_ADDR_PORT4_PU 16'hFF34
`define GPB_ADDR_PORT12_PU 16'hFF3C
`define GPB_ADDR_PORT2_AMS 16'hFF84
// ************************************************************
// implemented bits per register
// ************************************************************
`define GPB_MASK_PORT2 8'h0F
`define GPB_MASK_PORT3 8'h03
`define GPB_MASK_PORT3_IN 8'h10
`define GPB_MASK_PORT4 8'h3F
`define GPB_MASK_PORT12 8'h0E
`define GPB_MASK_PORT12_PU 8'h08
`define GPB_MASK_PORT13 8'h01
`define GPB_MASK_OSC_HS 8'h0E
`define GPB_MASK_OSC_XTAL 8'h08
`define GPB_MASK_OSC_EXT 8'h0C
// ************************************************************
// reset values
// ************************************************************
`define GPB_RST_DATA 8'h00
`define GPB_RST_DIR 8'hFF
`define GPB_RST_PU 8'h00
`define GPB_RST_AMS 8'h00
// ************************************************************
// synchronised pin vector layout
// ************************************************************
`define GPB_PIN_W 16
`define GPB_SYNC_STAGES 2
`endif

/* File: rtl/gpb_pkg.sv */
// types shared by the port block
package gpb_pkg;
    // system clock source chosen by the configuration byte
    typedef enum logic [1:0] {
        GPB_OSC_HS_INTERNAL,
        GPB_OSC_CRYSTAL,
        GPB_OSC_EXT_CLOCK
    } gpb_osc_e;

    typedef struct packed {
        logic [7:0] port2_data;
        logic [7:0] port3_data;
        logic [7:0] port4_data;
        logic [7:0] port12_data;
        logic [7:0] port13_data;
        logic [7:0] port2_direction;
        logic [7:0] port3_direction;
        logic [7:0] port4_direction;
        logic [7:0] port12_direction;
        logic [7:0] port2_pullup_select;
        logic [7:0] port3_pullup_select;
        logic [7:0] port4_pullup_select;
        logic [7:0] port12_pullup_select;
        logic [7:0] port2_analog_mode_select;
        logic [7:0] rd_data;
        logic [3:0] p2_out;
        logic [3:0] p2_oe;
        logic [3:0] p2_pu;
        logic [1:0] p3_out;
        logic [1:0] p3_oe;
        logic [1:0] p3_pu;
        logic [5:0] p4_out;
        logic [5:0] p4_oe;
        logic [5:0] p4_pu;
        logic [2:0] p12_out;
        logic [2:0] p12_oe;
        logic p12_pu;
        logic output_only_pin;
        logic [2:0] int_prev;
        logic [2:0] int_req;
        logic reset_hold_n;
    } gpb_state_s;
endpackage : gpb_pkg

/* File: rtl/gpb_sync.sv */
// two-stage synchroniser for the port pin inputs
`timescale 1ns/100ps
module gpb_sync #(
    parameter int W = 16
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } gpb_sync_s;

    gpb_sync_s st_reg;
    gpb_sync_s st_next;

    // first stage feeds only the second stage
    always_comb begin
        st_next = st_reg;
        st_next.s1 = d;
        st_next.s2 = st_reg.s1;
    end

    // register the stages
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_reg <= '0;
        end else if (ce) begin
            st_reg <= st_next;
        end
    end

    assign q = st_reg.s2;
endmodule : gpb_sync

/* File: rtl/gpb_top.sv */
// general-purpose port block: latches, direction, pull-ups and reads
`timescale 1ns/100ps
`include "gpb_map.svh"
module gpb_top (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic [15:0] addr,
    input wire logic wr,
    input wire logic bit_wr,
    input wire logic [2:0] bit_sel,
    input wire logic [7:0] wdata,
    input wire logic rd,
    output logic [7:0] rd_data,
    input wire gpb_pkg::gpb_osc_e osc_sel,
    input wire logic reset_pin_sel,
    input wire logic cfg_pending,
    input wire logic [3:0] p2_in,
    output logic [3:0] p2_out,
    output logic [3:0] p2_oe,
    output logic [3:0] p2_pu,
    input wire logic [1:0] p3_in,
    output logic [1:0] p3_out,
    output logic [1:0] p3_oe,
    output logic [1:0] p3_pu,
    input wire logic input_only_shared_reset_pin,
    input wire logic [5:0] p4_in,
    output logic [5:0] p4_out,
    output logic [5:0] p4_oe,
    output logic [5:0] p4_pu,
    input wire logic [2:0] p12_in,
    output logic [2:0] p12_out,
    output logic [2:0] p12_oe,
    output logic p12_pu,
    output logic output_only_pin,
    output logic [2:0] int_req,
    output logic reset_hold_n
);
    gpb_pkg::gpb_state_s st_reg;
    gpb_pkg::gpb_state_s st_next;
    logic [`GPB_PIN_W-1:0] pin_raw;
    logic [`GPB_PIN_W-1:0] pin_s;
    logic [7:0] pin2;
    logic [7:0] pin3;
    logic [7:0] pin4;
    logic [7:0] pin12;
    logic [7:0] osc_mask;
    logic [7:0] cur_val;
    logic [7:0] new_val;
    logic [2:0] int_pins;
    logic [2:0] int_out_mode;

    // ************************************************************
    // pin synchronisation
    // ************************************************************
    // shared reset pin stored inverted: cleared stages read as pin high
    assign pin_raw = {p12_in, p4_in, ~input_only_shared_reset_pin, p3_in,
        p2_in};

    gpb_sync #(
        .W(`GPB_PIN_W)
    ) u_sync (
        .clk(clk),
        .nrst(nrst),
        .ce(ce),
        .d(pin_raw),
        .q(pin_s)
    );

    // pin levels placed at their register bit positions
    assign pin2 = {4'h0, pin_s[3:0]};
    assign pin3 = {3'h0, ~pin_s[6], 2'h0, pin_s[5:4]};
    assign pin4 = {2'h0, pin_s[12:7]};
    assign pin12 = {4'h0, pin_s[15:13], 1'b0};

    // port 12 bits left to the port by the oscillator choice
    always_comb begin
        unique case (osc_sel)
            gpb_pkg::GPB_OSC_HS_INTERNAL: osc_mask = `GPB_MASK_OSC_HS;
            gpb_pkg::GPB_OSC_CRYSTAL: osc_mask = `GPB_MASK_OSC_XTAL;
            gpb_pkg::GPB_OSC_EXT_CLOCK: osc_mask = `GPB_MASK_OSC_EXT;
            default: osc_mask = `GPB_MASK_OSC_XTAL;
        endcase
    end

    // ************************************************************
    // register read value
    // ************************************************************
    // input bits show the pin, output bits the latch
    function automatic logic [7:0] mix(input logic [7:0] dir,
        input logic [7:0] pin, input logic [7:0] lat,
        input logic [7:0] msk);
        mix = ((dir & pin) | (~dir & lat)) & msk;
    endfunction : mix

    always_comb begin
        unique case (addr)
            `GPB_ADDR_PORT2_DATA: cur_val = mix(st_reg.port2_direction,
                pin2, st_reg.port2_data, `GPB_MASK_PORT2);
            `GPB_ADDR_PORT3_DATA: cur_val = mix(st_reg.port3_direction,
                pin3, st_reg.port3_data, `GPB_MASK_PORT3)
                | (pin3 & `GPB_MASK_PORT3_IN);
            `GPB_ADDR_PORT4_DATA: cur_val = mix(st_reg.port4_direction,
                pin4, st_reg.port4_data, `GPB_MASK_PORT4);
            `GPB_ADDR_PORT12_DATA: cur_val = mix(st_reg.port12_direction,
                pin12, st_reg.port12_data, osc_mask);
            `GPB_ADDR_PORT13_DATA: cur_val = st_reg.port13_data;
            `GPB_ADDR_PORT2_DIR: cur_val = st_reg.port2_direction;
            `GPB_ADDR_PORT3_DIR: cur_val = st_reg.port3_direction;
            `GPB_ADDR_PORT4_DIR: cur_val = st_reg.port4_direction;
            `GPB_ADDR_PORT12_DIR: cur_val = st_reg.port12_direction;
            `GPB_ADDR_PORT2_PU: cur_val = st_reg.port2_pullup_select;
            `GPB_ADDR_PORT3_PU: cur_val = st_reg.port3_pullup_select;
            `GPB_ADDR_PORT4_PU: cur_val = st_reg.port4_pullup_select;
            `GPB_ADDR_PORT12_PU: cur_val = st_reg.port12_pullup_select;
            `GPB_ADDR_PORT2_AMS: cur_val = st_reg.port2_analog_mode_select;
            default: cur_val = 8'h00;
        endcase
    end

    // bit write merges one bit into the whole byte as read
    always_comb begin
        new_val = wdata;
        if (bit_wr) begin
            new_val = cur_val;
            new_val[bit_sel] = wdata[bit_sel];
        end
    end

    // interrupt-shared pins: port 3 bits 0, 1 and port 4 bit 3
    assign int_pins = {pin_s[10], pin_s[5:4]};
    assign int_out_mode = {~st_reg.port4_direction[3],
        ~st_reg.port3_direction[1:0]};

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        st_next = st_reg;
        // register writes; unused bits held at fixed values
        if (wr) begin
            unique case (addr)
                `GPB_ADDR_PORT2_DATA:
                    st_next.port2_data = new_val & `GPB_MASK_PORT2;
                `GPB_ADDR_PORT3_DATA:
                    st_next.port3_data = new_val & `GPB_MASK_PORT3;
                `GPB_ADDR_PORT4_DATA:
                    st_next.port4_data = new_val & `GPB_MASK_PORT4;
                `GPB_ADDR_PORT12_DATA:
                    st_next.port12_data = new_val & `GPB_MASK_PORT12;
                `GPB_ADDR_PORT13_DATA:
                    st_next.port13_data = new_val & `GPB_MASK_PORT13;
                `GPB_ADDR_PORT2_DIR:
                    st_next.port2_direction = new_val | ~`GPB_MASK_PORT2;
                `GPB_ADDR_PORT3_DIR:
                    st_next.port3_direction = new_val | ~`GPB_MASK_PORT3;
                `GPB_ADDR_PORT4_DIR:
                    st_next.port4_direction = new_val | ~`GPB_MASK_PORT4;
                `GPB_ADDR_PORT12_DIR:
                    st_next.port12_direction = new_val | ~`GPB_MASK_PORT12;
                `GPB_ADDR_PORT2_PU:
                    st_next.port2_pullup_select = new_val & `GPB_MASK_PORT2;
                `GPB_ADDR_PORT3_PU:
                    st_next.port3_pullup_select = new_val & `GPB_MASK_PORT3;
                `GPB_ADDR_PORT4_PU:
                    st_next.port4_pullup_select = new_val & `GPB_MASK_PORT4;
                `GPB_ADDR_PORT12_PU:
                    st_next.port12_pullup_select =
                        new_val & `GPB_MASK_PORT12_PU;
                `GPB_ADDR_PORT2_AMS:
                    st_next.port2_analog_mode_select =
                        new_val & `GPB_MASK_PORT2;
                default: ;
            endcase
        end
        // read data captured on a read strobe
        if (rd) begin
            st_next.rd_data = cur_val;
        end
        // pin drivers: output when direction bit is 0, except port 2 analog-mode bits and port 12 bits taken by the oscillator
        st_next.p2_out = st_next.port2_data[3:0];
        st_next.p2_oe = ~st_next.port2_direction[3:0]
            & ~st_next.port2_analog_mode_select[3:0];
        st_next.p2_pu = st_next.port2_pullup_select[3:0]
            & st_next.port2_direction[3:0]
            & ~st_next.port2_analog_mode_select[3:0];
        st_next.p3_out = st_next.port3_data[1:0];
        st_next.p3_oe = ~st_next.port3_direction[1:0];
        st_next.p3_pu = st_next.port3_pullup_select[1:0]
            & st_next.port3_direction[1:0];
        st_next.p4_out = st_next.port4_data[5:0];
        st_next.p4_oe = ~st_next.port4_direction[5:0];
        st_next.p4_pu = st_next.port4_pullup_select[5:0]
            & st_next.port4_direction[5:0];
        st_next.p12_out = st_next.port12_data[3:1];
        st_next.p12_oe = ~st_next.port12_direction[3:1]
            & osc_mask[3:1];
        st_next.p12_pu = st_next.port12_pullup_select[3]
            & st_next.port12_direction[3] & osc_mask[3];
        st_next.output_only_pin = st_next.port13_data[0];
        // level change on an output-mode interrupt pin
        st_next.int_prev = int_pins;
        st_next.int_req = (int_pins ^ st_reg.int_prev) & int_out_mode;
        // shared reset pin low holds reset until it rises, while cfg_pending or reset_pin_sel is set
        st_next.reset_hold_n = ~(pin_s[6]
            & (cfg_pending | reset_pin_sel));
    end

    // ************************************************************
    // state register
    // ************************************************************
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_reg <= '0;
            st_reg.port2_data <= `GPB_RST_DATA;
            st_reg.port3_data <= `GPB_RST_DATA;
            st_reg.port4_data <= `GPB_RST_DATA;
            st_reg.port12_data <= `GPB_RST_DATA;
            st_reg.port13_data <= `GPB_RST_DATA;
            st_reg.port2_direction <= `GPB_RST_DIR;
            st_reg.port3_direction <= `GPB_RST_DIR;
            st_reg.port4_direction <= `GPB_RST_DIR;
            st_reg.port12_direction <= `GPB_RST_DIR;
            st_reg.port2_pullup_select <= `GPB_RST_PU;
            st_reg.port3_pullup_select <= `GPB_RST_PU;
            st_reg.port4_pullup_select <= `GPB_RST_PU;
            st_reg.port12_pullup_select <= `GPB_RST_PU;
            st_reg.port2_analog_mode_select <= `GPB_RST_AMS;
            st_reg.reset_hold_n <= 1'b1;
        end else if (ce) begin
            st_reg <= st_next;
        end
    end

    // outputs straight from the state register
    assign rd_data = st_reg.rd_data;
    assign p2_out = st_reg.p2_out;
    assign p2_oe = st_reg.p2_oe;
    assign p2_pu = st_reg.p2_pu;
    assign p3_out = st_reg.p3_out;
    assign p3_oe = st_reg.p3_oe;
    assign p3_pu = st_reg.p3_pu;
    assign p4_out = st_reg.p4_out;
    assign p4_oe = st_reg.p4_oe;
    assign p4_pu = st_reg.p4_pu;
    assign p12_out = st_reg.p12_out;
    assign p12_oe = st_reg.p12_oe;
    assign p12_pu = st_reg.p12_pu;
    assign output_only_pin = st_reg.output_only_pin;
    assign int_req = st_reg.int_req;
    assign reset_hold_n = st_reg.reset_hold_n;
endmodule : gpb_top

/* File: test/gpb_pins.sv */
// pin model: far-side drivers, pull-ups and the port's own buffers
`timescale 1ns/100ps
module gpb_pins #(
    parameter int W = 4
) (
    input wire logic clk,
    input wire logic [W-1:0] out,
    input wire logic [W-1:0] oe,
    input wire logic [W-1:0] pu,
    input wire logic [W-1:0] ext,
    input wire logic [W-1:0] en,
    output logic [W-1:0] lvl
);
    logic flt = 1'b0;
    // a released line with no pull-up changes every cycle
    always @(posedge clk) flt <= ~flt;
    // port buffer first, then the far driver, then the pull-up
    always_comb begin
        for (int i = 0; i < W; i++) begin
            lvl[i] = oe[i] ? out[i] : en[i] ? ext[i] : pu[i] | flt;
        end
    end
endmodule : gpb_pins

/* File: test/gpb_top_chk.sv */
// assertions on the port block's register port and pins
`timescale 1ns/100ps
`include "gpb_map.svh"
module gpb_chk (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [15:0] addr,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rd_data,
    input wire gpb_pkg::gpb_osc_e osc_sel,
    input wire logic reset_pin_sel,
    input wire logic cfg_pending,
    input wire logic input_only_shared_reset_pin,
    input wire logic [3:0] p2_oe,
    input wire logic [3:0] p2_pu,
    input wire logic [1:0] p3_oe,
    input wire logic [1:0] p3_pu,
    input wire logic [2:0] p12_oe,
    input wire logic p12_pu,
    input wire logic output_only_pin,
    input wire logic reset_hold_n
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    // shared reset pin low while it acts as reset, or back high
    sequence pin_holds;
        !input_only_shared_reset_pin && (cfg_pending || reset_pin_sel);
    endsequence
    sequence pin_high;
        input_only_shared_reset_pin;
    endsequence
    // pull-ups only on inputs, oscillator pins never driven
    pu_input_a: assert property (
        (p2_oe & p2_pu) == 4'h0 && (p3_oe & p3_pu) == 2'h0)
        else $error("pull-up on a driven pin");
    p12_pu_a: assert property (p12_pu |-> !p12_oe[2])
        else $error("port12 pull-up while driving");
    osc_xtal_a: assert property (osc_sel == gpb_pkg::GPB_OSC_CRYSTAL &&
        $stable(osc_sel) |-> p12_oe[1:0] == 2'h0)
        else $error("crystal pins driven");
    osc_ext_a: assert property (osc_sel == gpb_pkg::GPB_OSC_EXT_CLOCK &&
        $stable(osc_sel) |-> !p12_oe[0])
        else $error("clock input pin driven");
    // read data, the output-only pin and the reset hold
    p13_rise_a: assert property ($rose(output_only_pin) |->
        $past(wr && addr == `GPB_ADDR_PORT13_DATA))
        else $error("output-only pin rose without a write");
    rd_hold_a: assert property (!rd |=> $stable(rd_data))
        else $error("read data moved without a read");
    dir_fill_a: assert property (rd && addr == `GPB_ADDR_PORT2_DIR |=>
        rd_data[7:4] == 4'hF)
        else $error("unused direction bits not one");
    hold_low_a: assert property (pin_holds[*4] |-> !reset_hold_n)
        else $error("reset not held by low pin");
    hold_off_a: assert property (pin_high[*4] |-> reset_hold_n)
        else $error("reset held with pin high");
endmodule : gpb_chk
bind gpb_top gpb_chk i_gpb_chk (.clk(clk), .nrst(nrst), .addr(addr),
    .wr(wr), .rd(rd), .rd_data(rd_data), .osc_sel(osc_sel),
    .reset_pin_sel(reset_pin_sel), .cfg_pending(cfg_pending),
    .input_only_shared_reset_pin(input_only_shared_reset_pin),
    .p2_oe(p2_oe), .p2_pu(p2_pu), .p3_oe(p3_oe), .p3_pu(p3_pu),
    .p12_oe(p12_oe), .p12_pu(p12_pu), .output_only_pin(output_only_pin),
    .reset_hold_n(reset_hold_n));

/* File: test/gpb_top_tb.sv */
// self-checking bench for the port block
`timescale 1ns/100ps
module gpb_top_tb;
    logic clk = 1'b0, nrst = 1'b0, wr = 1'b0, bit_wr = 1'b0, rd = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic [2:0] bit_sel = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rd_data;
    gpb_pkg::gpb_osc_e osc_sel = gpb_pkg::GPB_OSC_HS_INTERNAL;
    logic reset_pin_sel = 1'b0, cfg_pending = 1'b0, sh_pin = 1'b1;
    logic [14:0] ext = 15'h0000, ext_en = 15'h7FFF;
    wire logic [14:0] lvl;
    logic [3:0] p2_out, p2_oe, p2_pu;
    logic [1:0] p3_out, p3_oe, p3_pu;
    logic [5:0] p4_out, p4_oe, p4_pu;
    logic [2:0] p12_out, p12_oe, int_req;
    logic p12_pu, output_only_pin, reset_hold_n;
    logic [3:0] ic [3] = '{4'h0, 4'h0, 4'h0};
    int bad_count = 0, cmp_count = 0, cyc = 0;
    logic [15:0] ra [15] = '{16'hFF02, 16'hFF03, 16'hFF04, 16'hFF0C,
        16'hFF0D, 16'hFF22, 16'hFF23, 16'hFF24, 16'hFF2C, 16'hFF32,
        16'hFF33, 16'hFF34, 16'hFF3C, 16'hFF84, 16'hFF10};

    always #2 clk = ~clk;

    gpb_top i_gpb_top (.clk(clk), .nrst(nrst), .ce(1'b1), .addr(addr),
        .wr(wr), .bit_wr(bit_wr), .bit_sel(bit_sel), .wdata(wdata),
        .rd(rd), .rd_data(rd_data), .osc_sel(osc_sel),
        .reset_pin_sel(reset_pin_sel), .cfg_pending(cfg_pending),
        .p2_in(lvl[3:0]), .p2_out(p2_out), .p2_oe(p2_oe), .p2_pu(p2_pu),
        .p3_in(lvl[5:4]), .p3_out(p3_out), .p3_oe(p3_oe), .p3_pu(p3_pu),
        .input_only_shared_reset_pin(sh_pin), .p4_in(lvl[11:6]),
        .p4_out(p4_out), .p4_oe(p4_oe), .p4_pu(p4_pu), .p12_in(lvl[14:12]),
        .p12_out(p12_out), .p12_oe(p12_oe), .p12_pu(p12_pu),
        .output_only_pin(output_only_pin), .int_req(int_req),
        .reset_hold_n(reset_hold_n));
    // attached devices on each port
    gpb_pins #(.W(4)) i_gpb_pins_p2 (.clk(clk), .out(p2_out), .oe(p2_oe),
        .pu(p2_pu), .ext(ext[3:0]), .en(ext_en[3:0]), .lvl(lvl[3:0]));
    gpb_pins #(.W(2)) i_gpb_pins_p3 (.clk(clk), .out(p3_out), .oe(p3_oe),
        .pu(p3_pu), .ext(ext[5:4]), .en(ext_en[5:4]), .lvl(lvl[5:4]));
    gpb_pins #(.W(6)) i_gpb_pins_p4 (.clk(clk), .out(p4_out), .oe(p4_oe),
        .pu(p4_pu), .ext(ext[11:6]), .en(ext_en[11:6]), .lvl(lvl[11:6]));
    gpb_pins #(.W(3)) i_gpb_pins_p12 (.clk(clk), .out(p12_out),
        .oe(p12_oe), .pu({p12_pu, 2'b00}), .ext(ext[14:12]),
        .en(ext_en[14:12]), .lvl(lvl[14:12]));

    // count request pulses per pin and guard against a hang
    always @(posedge clk) begin
        for (int i = 0; i < 3; i++) begin
            if (int_req[i] === 1'b1) ic[i] <= ic[i] + 4'h1;
        end
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            bad_count++;
            give_verdict();
        end
    end

    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        cmp_count++;
        if (s !== e) begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, s, e);
        end
    endtask : chk

    // one write strobe, byte or single bit
    task automatic wreg(input logic [15:0] a, input logic [7:0] d,
        input logic b, input logic [2:0] s);
        @(negedge clk);
        addr = a;
        wdata = d;
        bit_wr = b;
        bit_sel = s;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
        bit_wr = 1'b0;
    endtask : wreg

    task automatic rchk(input logic [15:0] a, input logic [7:0] e);
        @(negedge clk);
        addr = a;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        chk(rd_data, e);
    endtask : rchk

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : give_verdict

    initial begin
        repeat (4) @(negedge clk);
        nrst = 1'b1;
        // every register after reset, unmapped address last
        for (int i = 0; i < 15; i++) begin
            rchk(ra[i], (i > 4 && i < 9) ? 8'hFF : (i == 1) ? 8'h10 : 8'h00);
        end
        chk({p2_oe, 3'h0, output_only_pin}, 8'h00);
        $display("reset test done");
        wreg(16'hFF02, 8'h05, 1'b0, 3'h0);
        chk(8'(p2_oe), 8'h00);
        rchk(16'hFF02, 8'h00);
        wreg(16'hFF22, 8'h0C, 1'b0, 3'h0);
        rchk(16'hFF22, 8'hFC);
        chk({p2_oe, p2_out}, 8'h35);
        rchk(16'hFF02, 8'h01);
        ext_en[3:2] = 2'b00;
        wreg(16'hFF32, 8'hFF, 1'b0, 3'h0);
        rchk(16'hFF32, 8'h0F);
        chk(8'(p2_pu), 8'h0C);
        rchk(16'hFF02, 8'h0D);
        wreg(16'hFF22, 8'hFF, 1'b1, 3'h1);
        rchk(16'hFF22, 8'hFE);
        wreg(16'hFF02, 8'h00, 1'b1, 3'h0);
        chk(8'(p2_out), 8'h0C);
        wreg(16'hFF84, 8'hFF, 1'b0, 3'h0);
        rchk(16'hFF84, 8'h0F);
        chk({p2_oe, p2_pu}, 8'h00);
        wreg(16'hFF84, 8'h00, 1'b0, 3'h0);
        $display("port2 test done");
        wreg(16'hFF23, 8'hFE, 1'b0, 3'h0);
        wreg(16'hFF03, 8'h01, 1'b0, 3'h0);
        rchk(16'hFF03, 8'h11);
        chk(8'({p3_oe, p3_out, p3_pu}), 8'h14);
        wreg(16'hFF34, 8'hFF, 1'b0, 3'h0);
        chk(8'(p4_pu), 8'h3F);
        wreg(16'hFF24, 8'hC0, 1'b0, 3'h0);
        wreg(16'hFF04, 8'hFF, 1'b0, 3'h0);
        chk({p4_oe, p4_out[1:0]}, 8'hFF);
        chk(8'(p4_pu), 8'h00);
        rchk(16'hFF04, 8'h3F);
        ext[5] = 1'b1;
        repeat (6) @(negedge clk);
        ext[5] = 1'b0;
        repeat (6) @(negedge clk);
        chk({ic[2], ic[0]}, 8'h11);
        chk(8'(ic[1]), 8'h00);
        $display("port3 port4 test done");
        wreg(16'hFF2C, 8'h00, 1'b0, 3'h0);
        rchk(16'hFF2C, 8'hF1);
        wreg(16'hFF0C, 8'hFF, 1'b0, 3'h0);
        chk(8'(p12_out), 8'h07);
        rchk(16'hFF0C, 8'h0E);
        wreg(16'hFF3C, 8'hFF, 1'b0, 3'h0);
        rchk(16'hFF3C, 8'h08);
        chk(8'({p12_pu, p12_oe}), 8'h07);
        osc_sel = gpb_pkg::GPB_OSC_CRYSTAL;
        repeat (3) @(negedge clk);
        chk(8'(p12_oe), 8'h04);
        osc_sel = gpb_pkg::GPB_OSC_EXT_CLOCK;
        repeat (3) @(negedge clk);
        chk(8'(p12_oe), 8'h06);
        osc_sel = gpb_pkg::GPB_OSC_HS_INTERNAL;
        wreg(16'hFF2C, 8'hFF, 1'b0, 3'h0);
        chk(8'({p12_pu, p12_oe}), 8'h08);
        $display("port12 test done");
        sh_pin = 1'b0;
        repeat (6) @(negedge clk);
        rchk(16'hFF03, 8'h01);
        chk(8'(reset_hold_n), 8'h01);
        cfg_pending = 1'b1;
        repeat (6) @(negedge clk);
        chk(8'(reset_hold_n), 8'h00);
        cfg_pending = 1'b0;
        reset_pin_sel = 1'b1;
        repeat (6) @(negedge clk);
        chk(8'(reset_hold_n), 8'h00);
        sh_pin = 1'b1;
        repeat (6) @(negedge clk);
        chk(8'(reset_hold_n), 8'h01);
        reset_pin_sel = 1'b0;
        $display("shared pin test done");
        wreg(16'hFF0D, 8'hFF, 1'b0, 3'h0);
        chk(8'(output_only_pin), 8'h01);
        rchk(16'hFF0D, 8'h01);
        reset_pin_sel = 1'b1;
        nrst = 1'b0;
        #1;
        chk(8'(output_only_pin), 8'h00);
        repeat (2) @(negedge clk);
        nrst = 1'b1;
        @(negedge clk);
        chk(8'(reset_hold_n), 8'h01);
        reset_pin_sel = 1'b0;
        rchk(16'hFF0D, 8'h00);
        rchk(16'hFF23, 8'hFF);
        $display("output pin test done");
        give_verdict();
    end
endmodule : gpb_top_tb
